// ===== verilog/slew_timeout_pkg.sv
// Constants and carrier types for the slew and timeout trigger qualifier
package slew_timeout_pkg;

	// Register word offsets on the Avalon-MM slave
	localparam logic [3:0] OFS_CTRL    = 4'h0;                   // Control bits
	localparam logic [3:0] OFS_REF     = 4'h1;                   // Reference transition time
	localparam logic [3:0] OFS_VAR     = 4'h2;                   // Variation
	localparam logic [3:0] OFS_LIMIT   = 4'h3;                   // Timeout limit
	localparam logic [3:0] OFS_PULSE   = 4'h4;                   // Pulse width
	localparam logic [3:0] OFS_STATUS  = 4'h5;                   // Status flags, last measurement reads at 4'h6
	localparam int         ADDR_W      = 4;                      // Word address width

	// Control register field positions
	localparam int CTL_SLOPE_LO  = 0;                            // Slope select, 2 bits
	localparam int CTL_CMP_LO    = 2;                            // Comparison select, 2 bits
	localparam int CTL_TYPE      = 4;                            // 0 slew, 1 timeout
	localparam int CTL_STAYHI    = 5;                            // Timeout range stays high
	localparam int CTL_ACT_EN    = 6;                            // Global actions enable
	localparam int CTL_PULSE_EN  = 7;                            // Pulse action enable
	localparam int CTL_SOUND_EN  = 8;                            // Sound action enable
	localparam int CTL_POL       = 9;                            // Pulse polarity, 1 active high
	localparam int CTL_AUX_LO    = 10;                           // Aux output select, 2 bits
	localparam logic [31:0] CTRL_RESET = 32'h0000_0200;          // Reset value of control

	// Timing
	localparam int  CLK_HZ        = 100_000_000;                 // Sample clock rate
	localparam int  BEEP_GAP_S    = 1;                           // Least beep spacing, seconds
	localparam int  BEEP_GAP_CYC  = BEEP_GAP_S * CLK_HZ;         // Beep spacing in cycles

	// Edge direction selection
	typedef enum logic [1:0] {
		SLOPE_RISE = 2'b00,                                      // Rising only
		SLOPE_FALL = 2'b01,                                      // Falling only
		SLOPE_BOTH = 2'b10                                       // Both
	} slope_type;

	// Comparison relation
	typedef enum logic [1:0] {
		CMP_GT = 2'b00,                                          // Longer than reference
		CMP_LT = 2'b01,                                          // Shorter than reference
		CMP_EQ = 2'b10,                                          // Inside window
		CMP_NE = 2'b11                                           // Outside window
	} cmp_type;

	// Aux output source
	typedef enum logic [1:0] {
		AUX_TRIG = 2'b00,                                        // Trigger out
		AUX_LOW  = 2'b01,                                        // Static low
		AUX_HIGH = 2'b10,                                        // Static high
		AUX_RSVD = 2'b11                                         // Static low
	} aux_type;

	// Comparator results from the channel front end
	typedef struct packed {
		logic above_upper;                                       // Above upper level
		logic above_lower;                                       // Above lower level, with hysteresis
	} comp_type;

endpackage

// ===== verilog/slew_timeout_trigger.sv
// Slew-rate and timeout trigger qualifier with trigger actions and Avalon-MM registers
// What this block does
// - Slope select: rising, falling or both
// - Timing runs from start to stop crossing
// - Greater mode triggers above reference
// - Lower mode triggers below reference
// - Equal mode triggers inside reference window
// - Not-equal mode triggers outside window
// - Reference and variation registers set limits
// - Upper crossing starts fall, stops rise
// - Lower crossing starts rise, stops fall
// - Lower level equals channel threshold comparator
// - Timeout fires without crossing for limit
// - Timeout ranges stays high, stays low
// - Time limit register sets timeout
// - Channel hysteresis applies to all crossings
// - Actions fire only with global enable
// - All enabled actions fire together
// - Pulse on aux output, never stalls
// - Pulse enable coupled to aux select on every control write; the reset value leaves aux on trigger with pulse off
// - Pulse width and polarity programmable
// - Beep requests at least 1 s apart
`timescale 1ns/1ps
`default_nettype none

module slew_timeout_trigger #(
	parameter int TW           = 32,                                       // Timer width
	parameter int BEEP_GAP_CYC = slew_timeout_pkg::BEEP_GAP_CYC            // Beep spacing
) (
	input  wire logic                                  CLK,                // Sample clock
	input  wire logic                                  RST_B,              // Async reset, low
	input  wire logic                                  CE,                 // Clock enable
	input  wire slew_timeout_pkg::comp_type            COMP,               // Comparator results
	input  wire logic [slew_timeout_pkg::ADDR_W-1:0]   AVS_ADDRESS,        // Word address
	input  wire logic                                  AVS_READ,           // Read strobe
	input  wire logic                                  AVS_WRITE,          // Write strobe
	input  wire logic [31:0]                           AVS_WRITEDATA,      // Write data
	input  wire logic [3:0]                            AVS_BYTEENABLE,     // Byte enables
	output logic [31:0]                                AVS_READDATA,       // Read data
	output logic                                       AVS_WAITREQUEST,    // Wait request
	output logic                                       AUX_OUT,            // Aux output pin
	output logic                                       BEEP_REQ,           // Beep request pulse
	output logic                                       TRIG_EVENT          // Trigger event pulse
);

	////////////////////////////////////////////////////////////////////////////////
	// Helper functions

	// Saturating increment of a timer
	function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
		sat_inc = (&v) ? v : v + {{(TW-1){1'b0}}, 1'b1};
	endfunction

	// Byte-lane merge of a write into a register
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Registers and bus decode

	logic [31:0]   ctrl_r;                   // Control
	logic [TW-1:0] ref_r;                    // Reference time
	logic [TW-1:0] var_r;                    // Variation
	logic [TW-1:0] limit_r;                  // Timeout limit
	logic [TW-1:0] pwidth_r;                 // Pulse width
	logic [TW-1:0] meas_last_r;              // Last measured time
	logic          ack_r;                    // Access answered this cycle

	wire req_w   = (AVS_READ | AVS_WRITE) & ~ack_r;                        // New access
	wire wr_w    = AVS_WRITE & ack_r & CE;                                 // Write lands with answer
	wire wr_ctrl = wr_w & (AVS_ADDRESS == slew_timeout_pkg::OFS_CTRL);     // Control write
	wire wr_ref  = wr_w & (AVS_ADDRESS == slew_timeout_pkg::OFS_REF);      // Reference write
	wire wr_var  = wr_w & (AVS_ADDRESS == slew_timeout_pkg::OFS_VAR);      // Variation write
	wire wr_lim  = wr_w & (AVS_ADDRESS == slew_timeout_pkg::OFS_LIMIT);    // Limit write
	wire wr_pw   = wr_w & (AVS_ADDRESS == slew_timeout_pkg::OFS_PULSE);    // Width write

	// Control write with pulse enable and aux select coupled
	wire [31:0] ctrl_m = merge(ctrl_r, AVS_WRITEDATA, AVS_BYTEENABLE);
	wire        pen_chg = ctrl_m[slew_timeout_pkg::CTL_PULSE_EN] !=
			ctrl_r[slew_timeout_pkg::CTL_PULSE_EN];                        // Pulse enable changed
	wire [1:0]  aux_m = ctrl_m[slew_timeout_pkg::CTL_AUX_LO +: 2];         // Written aux select
	wire [1:0]  aux_new = (pen_chg && ctrl_m[slew_timeout_pkg::CTL_PULSE_EN]) ?
			2'(slew_timeout_pkg::AUX_TRIG) : aux_m;
	wire        pen_new = (aux_new == 2'(slew_timeout_pkg::AUX_TRIG));
	wire [31:0] ctrl_nxt = {ctrl_m[31:12], aux_new, ctrl_m[9:8], pen_new, ctrl_m[6:0]};

	// Field views
	wire [1:0] slope   = ctrl_r[slew_timeout_pkg::CTL_SLOPE_LO +: 2];
	wire [1:0] cmp     = ctrl_r[slew_timeout_pkg::CTL_CMP_LO +: 2];        // Comparison
	wire       to_mode = ctrl_r[slew_timeout_pkg::CTL_TYPE];               // Timeout selected
	wire       stay_hi = ctrl_r[slew_timeout_pkg::CTL_STAYHI];
	wire       act_en  = ctrl_r[slew_timeout_pkg::CTL_ACT_EN];             // Global enable
	wire       pul_en  = ctrl_r[slew_timeout_pkg::CTL_PULSE_EN];           // Pulse enable
	wire       snd_en  = ctrl_r[slew_timeout_pkg::CTL_SOUND_EN];           // Sound enable
	wire       pol     = ctrl_r[slew_timeout_pkg::CTL_POL];
	wire [1:0] aux_sel = ctrl_r[slew_timeout_pkg::CTL_AUX_LO +: 2];        // Aux select

	// Status word: sticky trigger seen and measurement running
	logic       meas_run_r;                  // Measurement running
	logic       trig_seen_r;                 // Sticky trigger seen
	wire [31:0] status_w = {30'h0, trig_seen_r, meas_run_r};

	// Read mux, unmapped reads return zero
	logic [31:0] rd_mux;
	always_comb begin
		case (AVS_ADDRESS)
			slew_timeout_pkg::OFS_CTRL:   rd_mux = ctrl_r;
			slew_timeout_pkg::OFS_REF:    rd_mux = 32'(ref_r);
			slew_timeout_pkg::OFS_VAR:    rd_mux = 32'(var_r);
			slew_timeout_pkg::OFS_LIMIT:  rd_mux = 32'(limit_r);
			slew_timeout_pkg::OFS_PULSE:  rd_mux = 32'(pwidth_r);
			slew_timeout_pkg::OFS_STATUS: rd_mux = status_w;
			4'h6:                         rd_mux = 32'(meas_last_r);
			default:                      rd_mux = 32'h0;
		endcase
	end

	// Bus answer one cycle after the request is seen
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ack_r           <= 1'b0;
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h0;
		end else if (CE) begin
			ack_r           <= req_w;
			AVS_WAITREQUEST <= ~req_w;
			AVS_READDATA    <= (req_w & AVS_READ) ? rd_mux : 32'h0;
		end
	end

	// Configuration registers
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_r   <= slew_timeout_pkg::CTRL_RESET;
			ref_r    <= '0;
			var_r    <= '0;
			limit_r  <= '0;
			pwidth_r <= {{(TW-1){1'b0}}, 1'b1};
		end else begin
			if (wr_ctrl) ctrl_r <= ctrl_nxt;
			if (wr_ref) ref_r <= TW'(merge(32'(ref_r), AVS_WRITEDATA, AVS_BYTEENABLE));
			if (wr_var) var_r <= TW'(merge(32'(var_r), AVS_WRITEDATA, AVS_BYTEENABLE));
			if (wr_lim) limit_r <= TW'(merge(32'(limit_r), AVS_WRITEDATA, AVS_BYTEENABLE));
			if (wr_pw) pwidth_r <= TW'(merge(32'(pwidth_r), AVS_WRITEDATA, AVS_BYTEENABLE));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Crossing detection

	// Comparators already carry channel hysteresis, lower one is the channel threshold
	logic hi_d_r;                            // Upper comparator, last cycle
	logic lo_d_r;                            // Lower comparator, last cycle
	wire  up_rise = COMP.above_upper & ~hi_d_r;     // Upward through upper
	wire  up_fall = ~COMP.above_upper & hi_d_r;     // Downward through upper
	wire  lo_rise = COMP.above_lower & ~lo_d_r;     // Upward through lower
	wire  lo_fall = ~COMP.above_lower & lo_d_r;     // Downward through lower

	wire rise_ok = (slope != 2'(slew_timeout_pkg::SLOPE_FALL));
	wire fall_ok = (slope != 2'(slew_timeout_pkg::SLOPE_RISE));

	////////////////////////////////////////////////////////////////////////////////
	// Transition-time measurement

	typedef enum logic [1:0] {
		M_IDLE = 2'b00,                      // Waiting for a start crossing
		M_RISE = 2'b01,                      // Timing a rising edge
		M_FALL = 2'b10                       // Timing a falling edge
	} meas_type;

	meas_type      mst_r;                    // Measurement state
	meas_type      mst_nxt;                  // Next state
	logic [TW-1:0] mcnt_r;                   // Transition timer
	logic          done;                     // Stop crossing reached

	// Measurement state machine
	always_comb begin
		mst_nxt = mst_r;
		done    = 1'b0;
		case (mst_r)
			M_IDLE: begin
				if (lo_rise && rise_ok) mst_nxt = M_RISE;
				else if (up_fall && fall_ok) mst_nxt = M_FALL;
			end
			M_RISE: begin
				if (up_rise) begin
					done    = 1'b1;
					mst_nxt = M_IDLE;
				end else if (lo_fall) mst_nxt = M_IDLE;
			end
			M_FALL: begin
				if (lo_fall) begin
					done    = 1'b1;
					mst_nxt = M_IDLE;
				end else if (up_rise) mst_nxt = M_IDLE;
			end
			default: mst_nxt = M_IDLE;
		endcase
	end

	// Measured time including the stop cycle
	wire [TW-1:0] meas = sat_inc(mcnt_r);

	// Window limits, saturating at both ends
	wire [TW:0]   hi_sum = {1'b0, ref_r} + {1'b0, var_r};
	wire [TW-1:0] win_hi = hi_sum[TW] ? {TW{1'b1}} : hi_sum[TW-1:0];
	wire [TW-1:0] win_lo = (var_r > ref_r) ? '0 : ref_r - var_r;
	wire          in_win = (meas >= win_lo) && (meas <= win_hi);

	// Relation check of a finished measurement
	logic cmp_hit;
	always_comb begin
		case (cmp)
			2'(slew_timeout_pkg::CMP_GT): cmp_hit = meas > ref_r;
			2'(slew_timeout_pkg::CMP_LT): cmp_hit = meas < ref_r;
			2'(slew_timeout_pkg::CMP_EQ): cmp_hit = in_win;
			default:                      cmp_hit = ~in_win;
		endcase
	end
	wire slew_trig = ~to_mode & done & cmp_hit;

	////////////////////////////////////////////////////////////////////////////////
	// Timeout detector

	logic [TW-1:0] tcnt_r;                   // Time on the selected side
	logic          to_fired_r;               // Fired once for this stay
	wire  side_ok  = stay_hi ? COMP.above_lower : ~COMP.above_lower;
	wire  crossing = lo_rise | lo_fall;
	wire  to_trig  = to_mode & side_ok & ~crossing & ~to_fired_r &
			(sat_inc(tcnt_r) >= limit_r);

	////////////////////////////////////////////////////////////////////////////////
	// Detector state

	// Crossing history, timers and measurement state
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			hi_d_r      <= 1'b0;
			lo_d_r      <= 1'b0;
			mst_r       <= M_IDLE;
			mcnt_r      <= '0;
			meas_last_r <= '0;
			tcnt_r      <= '0;
			to_fired_r  <= 1'b0;
		end else if (CE) begin
			hi_d_r <= COMP.above_upper;
			lo_d_r <= COMP.above_lower;
			mst_r  <= mst_nxt;
			mcnt_r <= (mst_r == M_IDLE) ? '0 : sat_inc(mcnt_r);
			if (done) meas_last_r <= meas;
			tcnt_r     <= (side_ok & ~crossing) ? sat_inc(tcnt_r) : '0;
			to_fired_r <= (side_ok & ~crossing) ? (to_fired_r | to_trig) : 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Trigger actions

	wire           trig     = slew_trig | to_trig;
	wire           fire     = trig & act_en;
	logic [TW-1:0] pcnt_r;                   // Pulse cycles left
	logic [31:0]   bgap_r;                   // Beep hold-off count
	wire           beep_ok  = (bgap_r == 32'h0);
	wire           pulse_on = (pcnt_r != '0);
	wire           aux_lvl  = (aux_sel == 2'(slew_timeout_pkg::AUX_HIGH));

	// Pulse, beep and event outputs; nothing here holds back the detectors
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pcnt_r      <= '0;
			bgap_r      <= 32'h0;
			AUX_OUT     <= 1'b0;
			BEEP_REQ    <= 1'b0;
			TRIG_EVENT  <= 1'b0;
			meas_run_r  <= 1'b0;
			trig_seen_r <= 1'b0;
		end else if (CE) begin
			// Fire cycle is the first pulse cycle, so the count holds the rest
			if (fire && pul_en) pcnt_r <= (pwidth_r == '0) ? '0 : pwidth_r - TW'(1);
			else if (pulse_on) pcnt_r <= pcnt_r - TW'(1);
			if (fire && snd_en && beep_ok) bgap_r <= 32'(BEEP_GAP_CYC - 1);
			else if (!beep_ok) bgap_r <= bgap_r - 32'h1;
			BEEP_REQ   <= fire & snd_en & beep_ok;
			AUX_OUT    <= pul_en ? ((pulse_on | (fire & (pwidth_r != '0))) ~^ pol) : aux_lvl;
			TRIG_EVENT <= trig;
			meas_run_r <= (mst_nxt != M_IDLE);
			trig_seen_r <= trig | (trig_seen_r & ~(wr_w &&
					(AVS_ADDRESS == slew_timeout_pkg::OFS_STATUS) && AVS_WRITEDATA[1]));
		end
	end

endmodule

`default_nettype wire

// ===== testbench/slew_timeout_trigger_sva.sv
// Checker for the bus handshake and trigger action outputs of the qualifier
`timescale 1ns/1ps
`default_nettype none
module slew_timeout_checker #(
	parameter int TW           = 32,         // Timer width
	parameter int BEEP_GAP_CYC = 100         // Least beep spacing in cycles
) (
	input wire logic                                CLK,             // Sample clock
	input wire logic                                RST_B,           // Async reset, low
	input wire logic                                CE,              // Clock enable
	input wire slew_timeout_pkg::comp_type          COMP,            // Comparator results
	input wire logic [slew_timeout_pkg::ADDR_W-1:0] AVS_ADDRESS,     // Word address
	input wire logic                                AVS_READ,        // Read strobe
	input wire logic                                AVS_WRITE,       // Write strobe
	input wire logic [31:0]                         AVS_WRITEDATA,   // Write data
	input wire logic [3:0]                          AVS_BYTEENABLE,  // Byte enables
	input wire logic [31:0]                         AVS_READDATA,    // Read data
	input wire logic                                AVS_WAITREQUEST, // Wait request
	input wire logic                                AUX_OUT,         // Aux output
	input wire logic                                BEEP_REQ,        // Beep request
	input wire logic                                TRIG_EVENT       // Trigger event
);
	////////////////////////////////////////////////////////////////////////////////
	logic [31:0] gap_r;   // Cycles since the last beep, saturating
	logic [31:0] gap_nxt; // Next gap count
	assign gap_nxt = BEEP_REQ ? 32'h0000_0001 : ((gap_r == 32'hffff_ffff) ? gap_r : gap_r + 32'h1);
	// Gap counter starts saturated so the first beep is always allowed
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			gap_r <= 32'hffff_ffff;
		end else begin
			gap_r <= gap_nxt;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	sequence s_req;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CE;
	endsequence
	sequence s_ack;
		!AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
	endsequence
	AST_ANSWER: assert property (s_req |=> s_ack)
		else $error("request not answered in one cycle");
	AST_ACK_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("answer held longer than one cycle");
	AST_NO_SPURIOUS: assert property (!(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST)
		else $error("answer without request");
	AST_RDATA_IDLE: assert property (AVS_WAITREQUEST |-> AVS_READDATA == 32'h0)
		else $error("read data not zero outside answer");
	AST_TRIG_ONE: assert property (TRIG_EVENT |=> !TRIG_EVENT)
		else $error("trigger event wider than one cycle");
	AST_BEEP_GAP: assert property (BEEP_REQ |-> gap_r >= BEEP_GAP_CYC)
		else $error("beep too soon after previous");
	AST_BEEP_CAUSE: assert property (BEEP_REQ |-> TRIG_EVENT || $past(TRIG_EVENT))
		else $error("beep without trigger");
	AST_BEEP_ONE: assert property (BEEP_REQ |=> !BEEP_REQ [*8])
		else $error("beep request repeated");
endmodule
bind slew_timeout_trigger slew_timeout_checker #(.TW(TW), .BEEP_GAP_CYC(BEEP_GAP_CYC)) chk_u (
	.CLK(CLK), .RST_B(RST_B), .CE(CE), .COMP(COMP), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .AUX_OUT(AUX_OUT), .BEEP_REQ(BEEP_REQ),
	.TRIG_EVENT(TRIG_EVENT));
`default_nettype wire

// ===== testbench/comp_front_model.sv
// Behavioural analog front end: a ramping level seen by two comparators
`timescale 1ns/1ps
`default_nettype none
module comp_front_model #(
	parameter int LO  = 10, // Channel threshold level
	parameter int HI  = 30, // Upper level
	parameter int HYS = 3   // Hysteresis half band
) (
	input wire logic                   clk,   // Sample clock
	input wire logic                   rst_b, // Reset, low
	input wire logic [7:0]             tgt,   // Level to head for
	input wire logic [7:0]             step,  // Cycles per level step
	output logic [7:0]                 level, // Present level
	output slew_timeout_pkg::comp_type comp   // Comparator results
);
	logic [7:0] div_r; // Step divider
	// Level moves one step toward the target every step cycles
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			level <= 8'h00;
			div_r <= 8'h00;
			comp <= '0;
		end else begin
			if (level != tgt && div_r + 8'h01 >= step) begin
				div_r <= 8'h00;
				level <= (level < tgt) ? level + 8'h01 : level - 8'h01;
			end else begin
				div_r <= div_r + 8'h01;
			end
			// Lower comparator is the channel threshold, both with hysteresis
			comp.above_lower <= comp.above_lower ? (level > LO - HYS) : (level > LO + HYS);
			comp.above_upper <= comp.above_upper ? (level > HI - HYS) : (level > HI + HYS);
		end
	end
endmodule
`default_nettype wire

// ===== testbench/test_slew_timeout_trigger.sv
// Self-checking bench for the slew and timeout trigger qualifier
`timescale 1ns/1ps
`default_nettype none
module test_slew_timeout_trigger;
	localparam int GAP = 60;                  // Shortened beep spacing
	logic clk, rst_b, rd, wr, aux, beep, trig, wreq, aux_idle;
	logic [3:0] adr;                          // Bus address
	logic [31:0] wdat, rdat, q;               // Bus data
	logic [7:0] tgt, step, level;             // Front end control
	slew_timeout_pkg::comp_type comp;         // Comparator results
	int bad_count, n_tests, cyc, trig_n, beep_n, pulse_n, run, last_w, t0, b0, p0;
	slew_timeout_trigger #(.TW(32), .BEEP_GAP_CYC(GAP)) dut_u (.CLK(clk), .RST_B(rst_b),
		.CE(1'b1), .COMP(comp), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
		.AVS_WAITREQUEST(wreq), .AUX_OUT(aux), .BEEP_REQ(beep), .TRIG_EVENT(trig));
	comp_front_model fe_u (.clk(clk), .rst_b(rst_b), .tgt(tgt), .step(step), .level(level),
		.comp(comp));
	////////////////////////////////////////////////////////////////////////////////
	// Counts events and measures aux pulses away from the idle level
	always @(posedge clk) begin
		cyc <= cyc + 1;
		trig_n <= trig_n + (trig === 1'b1);
		beep_n <= beep_n + (beep === 1'b1);
		if (aux !== aux_idle) begin
			run <= run + 1;
		end else begin
			if (run != 0) begin
				pulse_n <= pulse_n + 1;
				last_w <= run;
			end
			run <= 0;
		end
		if (cyc == 30000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// One Avalon-MM access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (wreq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input string what);
		bus(1'b0, a, 32'h0);
		chk(q, e, what);
	endtask
	task automatic move(input logic [7:0] t, input logic [7:0] s);
		@(posedge clk);
		tgt <= t;
		step <= s;
		do begin
			@(posedge clk);
		end while (level !== t);
		repeat (6) @(posedge clk);
	endtask
	task automatic snap();
		repeat (3) @(posedge clk);
		t0 = trig_n;
		b0 = beep_n;
		p0 = pulse_n;
	endtask
	// Control word: f packs {pol, sound, pulse, actions, stays high, timeout}
	function automatic logic [31:0] ctl(input logic [1:0] sl, cm, input logic [5:0] f,
		input logic [1:0] ax);
		return {20'h00000, ax, f, cm, sl};
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	logic [31:0] refs [4] = '{32'h50, 32'h50, 32'h28, 32'h28}; // Reference per mode
	logic [31:0] vars [4] = '{32'h0, 32'h0, 32'h8, 32'h8};     // Variation per mode
	logic [31:0] e_f [4] = '{32'h0, 32'h1, 32'h1, 32'h0};      // Fast edge triggers
	logic [31:0] e_s [4] = '{32'h1, 32'h0, 32'h0, 32'h1};      // Slow edge triggers
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rst_b, rd, wr, adr, wdat, tgt, step, aux_idle} = '0;
		{bad_count, n_tests, cyc, trig_n, beep_n, pulse_n, run, last_w} = '0;
		step = 8'h01;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		rd_chk(slew_timeout_pkg::OFS_CTRL, slew_timeout_pkg::CTRL_RESET, "ctrl reset");
		rd_chk(slew_timeout_pkg::OFS_PULSE, 32'h1, "width reset");
		rd_chk(4'h7, 32'h0, "unmapped read");
		bus(1'b1, slew_timeout_pkg::OFS_VAR, 32'h1234);
		rd_chk(slew_timeout_pkg::OFS_VAR, 32'h1234, "variation");
		bus(1'b1, slew_timeout_pkg::OFS_CTRL, ctl(2'h0, 2'h0, 6'h20, 2'h2));
		rd_chk(slew_timeout_pkg::OFS_CTRL, ctl(2'h0, 2'h0, 6'h20, 2'h2), "static aux");
		chk({31'h0, aux}, 32'h1, "aux static high");
		bus(1'b1, slew_timeout_pkg::OFS_CTRL, ctl(2'h0, 2'h0, 6'h28, 2'h2));
		rd_chk(slew_timeout_pkg::OFS_CTRL, ctl(2'h0, 2'h0, 6'h28, 2'h0), "pulse sets aux");
		bus(1'b1, slew_timeout_pkg::OFS_CTRL, ctl(2'h0, 2'h0, 6'h20, 2'h0));
		rd_chk(slew_timeout_pkg::OFS_CTRL, ctl(2'h0, 2'h0, 6'h28, 2'h0), "aux sets pulse");
		bus(1'b1, slew_timeout_pkg::OFS_PULSE, 32'h5);
		// Every comparison relation with a fast and a slow rising edge
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, slew_timeout_pkg::OFS_REF, refs[m]);
			bus(1'b1, slew_timeout_pkg::OFS_VAR, vars[m]);
			bus(1'b1, slew_timeout_pkg::OFS_CTRL, ctl(2'h0, m[1:0], 6'h2c, 2'h0));
			snap();
			move(8'h28, 8'h02);
			rd_chk(4'h6, 32'h28, "fast time");
			chk(32'(trig_n - t0), e_f[m], "fast edge");
			chk(32'(pulse_n - p0), e_f[m], "pulse count");
			move(8'h00, 8'h06);
			move(8'h28, 8'h06);
			chk(32'(trig_n - t0), e_f[m] + e_s[m], "slow edge");
			chk(32'(last_w), 32'h5, "pulse width");
			move(8'h00, 8'h02);
		end
		// Slope selection with a slow rise and a slow fall
		bus(1'b1, slew_timeout_pkg::OFS_REF, 32'h50);
		for (int s = 0; s < 3; s++) begin
			bus(1'b1, slew_timeout_pkg::OFS_CTRL, ctl(s[1:0], 2'h0, 6'h2c, 2'h0));
			snap();
			move(8'h28, 8'h06);
			chk(32'(trig_n - t0), {31'h0, s != 1}, "rise counted");
			move(8'h00, 8'h06);
			chk(32'(trig_n - t0), 32'(1 + (s == 2)), "fall counted");
		end
		// Return across the start level abandons the measurement
		bus(1'b1, slew_timeout_pkg::OFS_CTRL, ctl(2'h0, 2'h1, 6'h2c, 2'h0));
		snap();
		move(8'h18, 8'h02);
		move(8'h00, 8'h02);
		chk(32'(trig_n - t0), 32'h0, "abandoned edge");
		// Timeout, stays high, active low pulse, with a wiggle shorter than the limit
		bus(1'b1, slew_timeout_pkg::OFS_LIMIT, 32'h1e);
		bus(1'b1, slew_timeout_pkg::OFS_CTRL, ctl(2'h0, 2'h0, 6'h1f, 2'h0));
		aux_idle = 1'b1;
		snap();
		move(8'h14, 8'h01);
		move(8'h00, 8'h01);
		move(8'h14, 8'h01);
		move(8'h00, 8'h01);
		chk(32'(trig_n - t0), 32'h0, "short stays");
		move(8'h28, 8'h01);
		repeat (60) @(posedge clk);
		chk(32'(trig_n - t0), 32'h1, "stays high");
		chk(32'(pulse_n - p0), 32'h1, "low pulse");
		chk(32'(last_w), 32'h5, "low width");
		chk(32'(beep_n - b0), 32'h1, "beep");
		bus(1'b1, slew_timeout_pkg::OFS_CTRL, ctl(2'h0, 2'h0, 6'h1d, 2'h0));
		snap();
		move(8'h00, 8'h01);
		repeat (60) @(posedge clk);
		chk(32'(trig_n - t0), 32'h1, "stays low");
		// Actions disabled: event still seen, no pulse and no beep
		bus(1'b1, slew_timeout_pkg::OFS_CTRL, ctl(2'h0, 2'h0, 6'h39, 2'h0));
		aux_idle = 1'b0;
		snap();
		move(8'h14, 8'h01);
		move(8'h00, 8'h01);
		repeat (60) @(posedge clk);
		chk(32'(trig_n - t0), 32'h1, "raw event");
		chk(32'(pulse_n - p0 + beep_n - b0), 32'h0, "actions gated");
		// Two events inside the beep gap give one beep, a later one beeps again
		bus(1'b1, slew_timeout_pkg::OFS_REF, 32'h0);
		bus(1'b1, slew_timeout_pkg::OFS_CTRL, ctl(2'h2, 2'h0, 6'h3c, 2'h0));
		snap();
		move(8'h24, 8'h01);
		move(8'h04, 8'h01);
		chk(32'(trig_n - t0), 32'h2, "two events");
		chk(32'(beep_n - b0), 32'h1, "beep dropped");
		repeat (70) @(posedge clk);
		move(8'h24, 8'h01);
		chk(32'(beep_n - b0), 32'h2, "beep again");
		print_verdict();
	end
endmodule
`default_nettype wire
